// file: core/bit_sync.sv
// two-flop level synchroniser
// assumes the source level is held several clocks
`timescale 1ns/1ps
`include "pwr_tick_defs.svh"
module bit_sync #(
  parameter int STAGES = `SYNC_STAGES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // carried level
  sync_if.dst       s
);
  logic [STAGES-1:0] sh_q;
  logic [STAGES-1:0] sh_d;
  if (STAGES < 2) begin : g_bad_stages
    $error("bit_sync needs two stages");
  end
  always_comb begin
    sh_d = {sh_q[STAGES-2:0], s.raw};
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end
  assign s.synced = sh_q[STAGES-1];
endmodule

// file: core/power_fail_and_mains_tick.sv
// power-fail interrupt/reset sequencer and mains tick generator
// assumes power-fail sense and mains phase inputs are asynchronous levels
// Overview of operation
// - a power failure while running drives the nmi line low three clocks later (two-flop synchroniser plus register), for that alone
// - nmi stays low until the restart reset line has gone low
// - restart reset goes low 3 ms after nmi went low
// - restart reset stays low about 150 ms after power returns
// - the tick shares the irq line with the serial ports; cpu polls
// - one tick, irq and status bit 8 set, at most once per 3/4 of 1/60 s (about 12.5 ms)
// - the tick falls in the 270 to 330 degree window of the mains wave
// - a 9.8304 MHz processor clock enable is made here from the core clock by a phase accumulator
// - serial clock and baud rates do not derive from processor clock
`timescale 1ns/1ps
`include "pwr_tick_defs.svh"
module power_fail_and_mains_tick #(
  parameter int RST_DELAY_CYC = `RST_DELAY_CYC,
  parameter int RST_HOLD_CYC  = `RST_HOLD_CYC,
  parameter int TICK_MIN_CYC  = `TICK_MIN_CYC,
  parameter int CNT_W         = 24,
  parameter int CORE_HZ       = `CLK_HZ,
  parameter int CPU_HZ        = `CPU_CLK_HZ,
  parameter int SER_HZ        = `SER_CLK_HZ
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // supervisory inputs
  input  wire logic                   power_fail,
  input  wire logic                   mains_phase_win,
  input  wire logic                   tick_ack,
  input  wire logic                   uart_irq_b,
  // processor lines
  output logic                        nmi_b,
  output logic                        restart_reset_line_b,
  output logic                        irq_b,
  output logic [`STATUS_W-1:0]        status,
  // clock-rate enables
  output logic                        cpu_clk_en,
  output logic                        ser_clk_en
);
  localparam int ACC_W = 27;

  if (RST_DELAY_CYC < 1 || RST_HOLD_CYC < 1 ||
      TICK_MIN_CYC < 1) begin : g_bad_cnt
    $error("timing counts must be positive");
  end
  if (RST_DELAY_CYC >= (1 << CNT_W) || RST_HOLD_CYC >= (1 << CNT_W) ||
      TICK_MIN_CYC >= (1 << CNT_W)) begin : g_bad_width
    $error("CNT_W too narrow");
  end
  if (CPU_HZ < 1 || SER_HZ < 1 || CPU_HZ >= CORE_HZ ||
      SER_HZ >= CORE_HZ ||
      CORE_HZ >= (1 << (ACC_W - 1))) begin : g_bad_rate
    $error("rate enables need 0 < rate < core clock");
  end

  sync_if pf_s ();
  sync_if ph_s ();
  assign pf_s.raw = power_fail;
  assign ph_s.raw = mains_phase_win;
  bit_sync #(.STAGES(`SYNC_STAGES)) u_pf_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .s     (pf_s)
  );
  bit_sync #(.STAGES(`SYNC_STAGES)) u_ph_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .s     (ph_s)
  );
  logic pf;
  logic ph;
  assign pf = pf_s.synced;
  assign ph = ph_s.synced;

  // power-fail sequencer
  pwr_tick_pkg::pf_state_e st_q;
  pwr_tick_pkg::pf_state_e st_d;
  logic [CNT_W-1:0]        cnt_q;
  logic [CNT_W-1:0]        cnt_d;
  logic                    nmi_b_q;
  logic                    nmi_b_d;
  logic                    rrl_b_q;
  logic                    rrl_b_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    nmi_b_d = nmi_b_q;
    rrl_b_d = rrl_b_q;
    case (st_q)
      pwr_tick_pkg::ST_RUN: begin
        cnt_d = '0;
        if (pf) begin
          nmi_b_d = 1'b0;
          st_d    = pwr_tick_pkg::ST_NMI;
        end
      end
      pwr_tick_pkg::ST_NMI: begin
        if (cnt_q == CNT_W'(RST_DELAY_CYC - 1)) begin
          rrl_b_d = 1'b0;
          cnt_d   = '0;
          st_d    = pwr_tick_pkg::ST_RESET;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      pwr_tick_pkg::ST_RESET: begin
        nmi_b_d = 1'b1;
        cnt_d   = '0;
        if (!pf) begin
          st_d = pwr_tick_pkg::ST_HOLD;
        end
      end
      pwr_tick_pkg::ST_HOLD: begin
        if (pf) begin
          cnt_d = '0;
          st_d  = pwr_tick_pkg::ST_RESET;
        end else if (cnt_q == CNT_W'(RST_HOLD_CYC - 1)) begin
          rrl_b_d = 1'b1;
          st_d    = pwr_tick_pkg::ST_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        st_d    = pwr_tick_pkg::ST_RUN;
        cnt_d   = '0;
        nmi_b_d = 1'b1;
        rrl_b_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= pwr_tick_pkg::ST_HOLD;
      cnt_q   <= '0;
      nmi_b_q <= 1'b1;
      rrl_b_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      nmi_b_q <= nmi_b_d;
      rrl_b_q <= rrl_b_d;
    end
  end

  // mains tick: one per entry into the phase window, rate limited
  logic             ph_q;
  logic             ph_d;
  logic [CNT_W-1:0] gap_q;
  logic [CNT_W-1:0] gap_d;
  logic             flag_q;
  logic             flag_d;
  logic             fire;

  always_comb begin
    ph_d   = ph;
    fire   = ph && !ph_q && (gap_q == '0) && rrl_b_q;
    gap_d  = gap_q;
    if (fire) begin
      gap_d = CNT_W'(TICK_MIN_CYC - 1);
    end else if (gap_q != '0) begin
      gap_d = gap_q - 1'b1;
    end
    flag_d = flag_q;
    if (fire) begin
      flag_d = 1'b1;
    end else if (tick_ack) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q   <= 1'b0;
      gap_q  <= '0;
      flag_q <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      gap_q  <= gap_d;
      flag_q <= flag_d;
    end
  end

  // rate enables from phase accumulators: exact average for a non-integer
  // ratio; the serial one has its own accumulator so a processor rate
  // change leaves the baud clock alone
  logic [1:0] rate_en;
  for (genvar g = 0; g < 2; g++) begin : g_rate
    localparam int INC = (g == 0) ? CPU_HZ : SER_HZ;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [ACC_W-1:0] sum;
    logic             en_q;
    logic             en_d;
    always_comb begin
      sum   = acc_q + ACC_W'(INC);
      en_d  = (sum >= ACC_W'(CORE_HZ));
      acc_d = en_d ? sum - ACC_W'(CORE_HZ) : sum;
    end
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        acc_q <= '0;
        en_q  <= 1'b0;
      end else begin
        acc_q <= acc_d;
        en_q  <= en_d;
      end
    end
    assign rate_en[g] = en_q;
  end

  assign nmi_b                = nmi_b_q;
  assign restart_reset_line_b = rrl_b_q;
  assign irq_b   = uart_irq_b & ~flag_q;
  assign status  = {flag_q, {(`STATUS_W-1){1'b0}}};
  assign cpu_clk_en = rate_en[0];
  assign ser_clk_en = rate_en[1];
endmodule

// file: dv/cpu_model.sv
// processor model: acks ticks, raises serial requests
// assumes it shares clk with the block
`timescale 1ns/1ps
module cpu_model #(
  parameter int LAT = 3
) (
  // clock
  input  wire logic       clk,
  // block lines
  input  wire logic       restart_b,
  input  wire logic       irq_b,
  input  wire logic [8:0] status,
  output logic            tick_ack,
  // serial ports
  input  wire logic       ser_req,
  output logic            uart_irq_b
);
  int w = 0;
  logic [7:0] map_init_q = 8'h00;
  assign uart_irq_b = !ser_req;
  // startup software maps its registers first thing out of reset
  always @(posedge clk) begin
    map_init_q <= restart_b ? 8'h77 : 8'h00;
  end
  // polls status to tell the tick from a serial request
  always @(posedge clk) begin
    w <= (!irq_b && status[8]) ? w + 1 : 0;
    tick_ack <= !irq_b && status[8] && w == LAT && map_init_q == 8'h77;
  end
endmodule

// file: dv/pf_tick_asserts.sv
// port checker for the power-fail sequencer and tick
// assumes one clock domain, bound to the design top
`timescale 1ns/1ps
`include "pwr_tick_defs.svh"
module pf_tick_asserts #(
  parameter int RST_DELAY_CYC = 30,
  parameter int RST_HOLD_CYC  = 100,
  parameter int TICK_MIN_CYC  = 50
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // inputs
  input wire logic                 power_fail,
  input wire logic                 mains_phase_win,
  input wire logic                 uart_irq_b,
  // outputs
  input wire logic                 nmi_b,
  input wire logic                 restart_reset_line_b,
  input wire logic                 irq_b,
  input wire logic [`STATUS_W-1:0] status,
  // rate enables
  input wire logic                 cpu_clk_en,
  input wire logic                 ser_clk_en
);
  int dly_q;
  int hld_q;
  int gap_q;
  logic s8_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_q <= 0;
      hld_q <= 0;
      gap_q <= TICK_MIN_CYC;
      s8_q <= 1'b0;
    end else begin
      dly_q <= (!nmi_b && restart_reset_line_b) ? dly_q + 1 : 0;
      hld_q <= (!restart_reset_line_b && !power_fail) ? hld_q + 1 : 0;
      gap_q <= (status[8] && !s8_q) ? 1 : gap_q + 1;
      s8_q <= status[8];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_fail;
    $rose(power_fail) && nmi_b && restart_reset_line_b;
  endsequence
  property p_nmi_fast; s_fail |-> ##[1:4] !nmi_b; endproperty
  a_nmi_fast: assert property (p_nmi_fast) else $error("nmi");
  property p_sync; s_fail |=> nmi_b; endproperty
  a_sync: assert property (p_sync) else $error("sync");
  property p_nmi_hold; !nmi_b && restart_reset_line_b |=> !nmi_b;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi");
  property p_rst_dly; $fell(restart_reset_line_b) |->
    dly_q >= RST_DELAY_CYC - 1 && dly_q <= RST_DELAY_CYC + 1; endproperty
  a_rst_dly: assert property (p_rst_dly) else $error("dly");
  property p_hold; $rose(restart_reset_line_b) |-> hld_q >= RST_HOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_irq; irq_b == (uart_irq_b && !status[8]); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_gap; $rose(status[8]) |-> gap_q >= TICK_MIN_CYC; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_win; $rose(status[8]) |->
    $past(mains_phase_win, 2) && restart_reset_line_b; endproperty
  a_win: assert property (p_win) else $error("win");
  sequence s_pace(en);
    !en [*4] ##[1:2] en;
  endsequence
  property p_cpu_rate; cpu_clk_en |=> s_pace(cpu_clk_en); endproperty
  a_cpu_rate: assert property (p_cpu_rate) else $error("cpu rate");
  property p_ser_rate; ser_clk_en |=> s_pace(ser_clk_en); endproperty
  a_ser_rate: assert property (p_ser_rate) else $error("ser rate");
endmodule
bind power_fail_and_mains_tick pf_tick_asserts #(
  .RST_DELAY_CYC (RST_DELAY_CYC),
  .RST_HOLD_CYC  (RST_HOLD_CYC),
  .TICK_MIN_CYC  (TICK_MIN_CYC)
) u_chk (
  .clk                  (clk),
  .rst_b                (rst_b),
  .power_fail           (power_fail),
  .mains_phase_win      (mains_phase_win),
  .uart_irq_b           (uart_irq_b),
  .nmi_b                (nmi_b),
  .restart_reset_line_b (restart_reset_line_b),
  .irq_b                (irq_b),
  .status               (status),
  .cpu_clk_en           (cpu_clk_en),
  .ser_clk_en           (ser_clk_en)
);

// file: dv/tb_power_fail_and_mains_tick.sv
// bench for the power-fail sequencer and tick
// assumes shortened counts and the processor model
`timescale 1ns/1ps
`include "pwr_tick_defs.svh"
module tb_power_fail_and_mains_tick;
  localparam int DLY = 30;
  localparam int HLD = 100;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic power_fail = 1'b0;
  logic mains_phase_win = 1'b0;
  logic ser_req = 1'b0;
  logic tick_ack, uart_irq_b, nmi_b, rl_b, irq_b;
  logic cpu_clk_en, ser_clk_en;
  logic [`STATUS_W-1:0] status;
  int failures = 0;
  int checks = 0;
  int n;
  always #10 clk = ~clk;
  power_fail_and_mains_tick #(.RST_DELAY_CYC(DLY), .RST_HOLD_CYC(HLD),
    .TICK_MIN_CYC(50)) uut (.clk(clk), .rst_b(rst_b),
    .power_fail(power_fail), .mains_phase_win(mains_phase_win),
    .tick_ack(tick_ack), .uart_irq_b(uart_irq_b), .nmi_b(nmi_b),
    .restart_reset_line_b(rl_b), .irq_b(irq_b), .status(status),
    .cpu_clk_en(cpu_clk_en), .ser_clk_en(ser_clk_en));
  cpu_model cpu (.clk(clk), .restart_b(rl_b), .irq_b(irq_b), .status(status),
    .tick_ack(tick_ack), .ser_req(ser_req), .uart_irq_b(uart_irq_b));
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic startup;
    rst_b = 1'b1;
    wait_lvl(rl_b, 1'b1);
    check("hold", n >= HLD && n <= HLD + 4, 1'b1);
  endtask
  task automatic rates;
    int c_cpu;
    int c_ser;
    c_cpu = 0;
    c_ser = 0;
    repeat (`CLK_HZ / 3200) begin
      @(negedge clk);
      c_cpu += cpu_clk_en;
      c_ser += ser_clk_en;
    end
    check("cpu clk", c_cpu, `CPU_CLK_HZ / 3200);
    check("ser clk", c_ser, `SER_CLK_HZ / 3200);
  endtask
  task automatic tick;
    mains_phase_win = 1'b1;
    wait_lvl(irq_b, 1'b0);
    check("tick lat", n, 3);
    check("flag", status[8], 1'b1);
    wait_lvl(irq_b, 1'b1);
    check("flag clr", status, 9'h000);
    mains_phase_win = 1'b0;
    repeat (5) @(negedge clk);
    mains_phase_win = 1'b1;
    repeat (10) @(negedge clk);
    check("early", status[8], 1'b0);
    mains_phase_win = 1'b0;
    repeat (50) @(negedge clk);
    mains_phase_win = 1'b1;
    wait_lvl(irq_b, 1'b0);
    check("tick2", n, 3);
    mains_phase_win = 1'b0;
    wait_lvl(irq_b, 1'b1);
    ser_req = 1'b1;
    @(negedge clk);
    check("uart", {irq_b, status[8]}, 2'h0);
    ser_req = 1'b0;
  endtask
  task automatic pfail;
    power_fail = 1'b1;
    wait_lvl(nmi_b, 1'b0);
    check("nmi lat", n, 3);
    wait_lvl(rl_b, 1'b0);
    check("res dly", n, DLY);
    check("nmi low", nmi_b, 1'b0);
    mains_phase_win = 1'b1;
    repeat (20) @(negedge clk);
    check("no tick", {rl_b, nmi_b, status[8]}, 3'h2);
    mains_phase_win = 1'b0;
    power_fail = 1'b0;
    repeat (40) @(negedge clk);
    power_fail = 1'b1;
    repeat (10) @(negedge clk);
    check("no renmi", {rl_b, nmi_b}, 2'h1);
    power_fail = 1'b0;
    wait_lvl(rl_b, 1'b1);
    check("restore", n, HLD + 3);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    startup;
    rates;
    tick;
    pfail;
    summarize;
  end
  initial begin
    #400000;
    failures++;
    summarize;
  end
endmodule

// file: include/pwr_tick_defs.svh
// timing constants for the power-fail sequencer and mains tick
// assumes a 50 MHz core clock
`ifndef PWR_TICK_DEFS_SVH
`define PWR_TICK_DEFS_SVH
`define CLK_HZ            50000000
`define RST_DELAY_US      3000
`define RST_DELAY_CYC     ((`RST_DELAY_US * (`CLK_HZ / 1000000)))
`define RST_HOLD_MS       150
`define RST_HOLD_CYC      ((`RST_HOLD_MS * (`CLK_HZ / 1000)))
`define TICK_PERIOD_US    16667
`define TICK_MIN_CYC      ((`TICK_PERIOD_US * (`CLK_HZ / 1000000)) * 3 / 4)
`define PHASE_LO_DEG      270
`define PHASE_HI_DEG      330
`define STATUS_TICK_BIT   8
`define STATUS_W          9
`define SYNC_STAGES       2
`define CPU_CLK_HZ        9830400
`define SER_CLK_HZ        9830400
`endif

// file: include/pwr_tick_pkg.sv
// types shared by the power-fail sequencer files
package pwr_tick_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_NMI   = 2'b01,
    ST_RESET = 2'b11,
    ST_HOLD  = 2'b10
  } pf_state_e;
endpackage

// file: include/sync_if.sv
// carrier between top and the input synchroniser
// assumes both ends share clk
`timescale 1ns/1ps
interface sync_if;
  logic raw;
  logic synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface
